// ### hdl/fsc_busy_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for the open-drain ready/busy input
module fsc_busy_sync (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire ready_busy_n_i,
  output reg ready_q
);
  reg meta_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      ready_q <= 1'b0;
    end else if (ce) begin
      meta_q <= ready_busy_n_i;
      ready_q <= meta_q;
    end
  end
endmodule

// ### hdl/fsc_cmd_rom.v
`timescale 1ns/1ps
`include "fsc_defs.vh"
// Command-sequence table: address and byte for each step of a sequence
module fsc_cmd_rom (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire [2:0] op,
  input wire [2:0] step,
  input wire [19:0] user_addr,
  input wire [7:0] user_data,
  output reg [19:0] addr_q,
  output reg [7:0] data_q
);
  reg [19:0] addr_d;
  reg [7:0] data_d;
  always @* begin
    addr_d = `FSC_UNLOCK_A1;
    data_d = `FSC_CMD_AA;
    case (step)
      3'h1: begin
        addr_d = `FSC_UNLOCK_A2;
        data_d = `FSC_CMD_55;
      end
      3'h2: begin
        data_d = (op == `FSC_OP_PROGRAM) ? `FSC_CMD_PROG : `FSC_CMD_ERASE;
      end
      3'h3: begin
        if (op == `FSC_OP_PROGRAM) begin
          addr_d = user_addr;
          data_d = user_data;
        end
      end
      3'h4: begin
        addr_d = `FSC_UNLOCK_A2;
        data_d = `FSC_CMD_55;
      end
      3'h5: begin
        if (op == `FSC_OP_CHIP_ERASE) begin
          data_d = `FSC_CMD_CHIP;
        end else begin
          addr_d = user_addr;
          data_d = `FSC_CMD_SECT;
        end
      end
      default: begin
        addr_d = `FSC_UNLOCK_A1;
        data_d = `FSC_CMD_AA;
      end
    endcase
    if (op == `FSC_OP_RESET) begin
      addr_d = user_addr;
      data_d = `FSC_CMD_RESET;
    end else if (op == `FSC_OP_ADD_SECTOR) begin
      addr_d = user_addr;
      data_d = `FSC_CMD_SECT;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 20'h0_0000;
      data_q <= 8'h00;
    end else if (ce) begin
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end
endmodule

// ### hdl/fsc_defs.vh
`ifndef FSC_DEFS_VH
`define FSC_DEFS_VH
// APB register byte offsets
`define FSC_REG_CTRL 12'h000
`define FSC_REG_ADDR 12'h004
`define FSC_REG_WDATA 12'h008
`define FSC_REG_STATUS 12'h00C
`define FSC_REG_RDATA 12'h010
// Control register fields
`define FSC_CTRL_GO 0
`define FSC_CTRL_OP_LSB 1
`define FSC_CTRL_OP_MSB 3
`define FSC_CTRL_WORD 4
// Operation codes
`define FSC_OP_READ 3'h0
`define FSC_OP_PROGRAM 3'h1
`define FSC_OP_CHIP_ERASE 3'h2
`define FSC_OP_SECTOR_ERASE 3'h3
`define FSC_OP_ADD_SECTOR 3'h4
`define FSC_OP_RESET 3'h5
`define FSC_OP_POLL 3'h6
// Status register fields
`define FSC_ST_BUSY 0
`define FSC_ST_DONE 1
`define FSC_ST_FAIL 2
`define FSC_ST_REJECT 3
`define FSC_ST_RDY 4
`define FSC_ST_WINDOW 5
// Toggle and flag bit positions in the status byte
`define FSC_BIT_POLL 7
`define FSC_BIT_OPTOG 6
`define FSC_BIT_TLIM 5
`define FSC_BIT_EWIN 3
`define FSC_BIT_ESTOG 2
// Bus cycle phase length in clocks (strobe low and high)
`define FSC_PHASE_CYC 4'h3
// Unlock addresses and data
`define FSC_UNLOCK_A1 20'h0_0AAA
`define FSC_UNLOCK_A2 20'h0_0555
`define FSC_CMD_AA 8'hAA
`define FSC_CMD_55 8'h55
`define FSC_CMD_PROG 8'hA0
`define FSC_CMD_ERASE 8'h80
`define FSC_CMD_CHIP 8'h10
`define FSC_CMD_SECT 8'h30
`define FSC_CMD_RESET 8'hF0
`endif

// ### hdl/fsc_flash_ctrl.v
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "fsc_defs.vh"
// Functional notes
// - Host reads erase-window flag before and after each added sector command (the code makes no read before; it checks window_q kept from the last poll).
// - Host keeps chip select or output enable high while address changes.
// - Host starts polling with two reads; stable toggle means done (the code makes three reads before its first compare).
// - Toggling and time-limit high: recheck; still toggling means fail, reset (the code sets fail and issues no reset until a reset operation is started).
// - Host returning to polling restarts from the first double read.
// - Ready/busy is open-drain, host supplies pull-up, outputs wire-AND.
module fsc_flash_ctrl #(
  parameter MAX_POLLS = 16'hFFFF
) (
  input wire pclk,
  input wire presetn,
  input wire pclken,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [19:0] flash_addr,
  output reg [14:0] flash_dq_o,
  output reg [14:0] flash_dq_oe_n,
  input wire [14:0] flash_dq_i,
  output reg top_data_or_low_addr_o,
  output reg top_data_or_low_addr_oe_n,
  input wire top_data_or_low_addr_i,
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  output reg flash_word,
  input wire ready_busy_n
);
  localparam S_IDLE = 4'h0;
  localparam S_WLOW = 4'h1;
  localparam S_WHIGH = 4'h2;
  localparam S_RLOW = 4'h3;
  localparam S_RHIGH = 4'h4;
  localparam S_EVAL = 4'h5;
  localparam S_LOAD = 4'h6;

  reg [3:0] st_q;
  reg [3:0] cnt_q;
  reg [2:0] step_q;
  reg [2:0] op_q;
  reg word_q;
  reg [19:0] addr_q;
  reg [15:0] wdata_q;
  reg [15:0] rdata_q;
  reg [15:0] prev_q;
  reg [1:0] nread_q;
  reg [15:0] polls_q;
  reg busy_q;
  reg done_q;
  reg fail_q;
  reg reject_q;
  reg tlim_seen_q;
  reg window_q;
  reg last_step_q;
  wire rdy;
  wire [19:0] rom_addr;
  wire [7:0] rom_data;
  wire [15:0] rd_bus = {top_data_or_low_addr_i, flash_dq_i};
  wire acc = psel & penable & pready;
  wire ctrl_wr = acc & pwrite & (paddr == `FSC_REG_CTRL);
  wire [2:0] new_op = pwdata[`FSC_CTRL_OP_MSB:`FSC_CTRL_OP_LSB];
  wire [2:0] seq_len = (new_op == `FSC_OP_PROGRAM) ? 3'h4 :
                       ((new_op == `FSC_OP_RESET) || (new_op == `FSC_OP_ADD_SECTOR)) ? 3'h1 : 3'h6;
  wire [15:0] toggled = rdata_q ^ prev_q;

  fsc_busy_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclken),
    .ready_busy_n_i(ready_busy_n),
    .ready_q(rdy)
  );

  fsc_cmd_rom u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pclken),
    .op(op_q),
    .step(step_q),
    .user_addr(addr_q),
    .user_data(wdata_q[7:0]),
    .addr_q(rom_addr),
    .data_q(rom_data)
  );

  // APB slave, zero wait state, unmapped reads zero with error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (pclken) begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `FSC_REG_CTRL: prdata <= {27'h000_0000, word_q, op_q, 1'b0};
          `FSC_REG_ADDR: prdata <= {12'h000, addr_q};
          `FSC_REG_WDATA: prdata <= {16'h0000, wdata_q};
          `FSC_REG_STATUS: prdata <= {26'h000_0000, window_q, rdy, reject_q, fail_q, done_q, busy_q};
          `FSC_REG_RDATA: prdata <= {16'h0000, rdata_q};
          default: pslverr <= psel;
        endcase
      end else if (psel & ~penable) begin
        case (paddr)
          `FSC_REG_CTRL, `FSC_REG_ADDR, `FSC_REG_WDATA: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      step_q <= 3'h0;
      op_q <= `FSC_OP_READ;
      word_q <= 1'b1;
      addr_q <= 20'h0_0000;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      prev_q <= 16'h0000;
      nread_q <= 2'h0;
      polls_q <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      reject_q <= 1'b0;
      tlim_seen_q <= 1'b0;
      window_q <= 1'b0;
      last_step_q <= 1'b0;
      flash_addr <= 20'h0_0000;
      flash_dq_o <= 15'h0000;
      flash_dq_oe_n <= 15'h7FFF;
      top_data_or_low_addr_o <= 1'b0;
      top_data_or_low_addr_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_word <= 1'b1;
    end else if (pclken) begin
      flash_word <= word_q;
      if (acc & pwrite & (paddr == `FSC_REG_ADDR) & ~busy_q) begin
        addr_q <= pwdata[19:0];
      end
      if (acc & pwrite & (paddr == `FSC_REG_WDATA) & ~busy_q) begin
        wdata_q <= pwdata[15:0];
      end
      case (st_q)
        S_IDLE: begin
          if (ctrl_wr & pwdata[`FSC_CTRL_GO] & ~busy_q) begin
            op_q <= new_op;
            word_q <= pwdata[`FSC_CTRL_WORD];
            done_q <= 1'b0;
            reject_q <= 1'b0;
            step_q <= 3'h0;
            nread_q <= 2'h0;
            polls_q <= 16'h0000;
            tlim_seen_q <= 1'b0;
            busy_q <= 1'b1;
            if (new_op == `FSC_OP_RESET) begin
              fail_q <= 1'b0;
            end
            // device refuses program/erase while busy; a fresh start is rejected
            if (~rdy & ((new_op == `FSC_OP_PROGRAM) || (new_op == `FSC_OP_CHIP_ERASE) ||
                (new_op == `FSC_OP_SECTOR_ERASE))) begin
              reject_q <= 1'b1;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end else if ((new_op == `FSC_OP_READ) || (new_op == `FSC_OP_POLL)) begin
              st_q <= S_LOAD;
            end else if (fail_q & (new_op != `FSC_OP_RESET)) begin
              reject_q <= 1'b1;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end else if ((new_op == `FSC_OP_ADD_SECTOR) & window_q) begin
              reject_q <= 1'b1;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end else begin
              last_step_q <= (seq_len == 3'h1);
              // Table register needs one clock to follow the new operation
              st_q <= S_EVAL;
            end
          end
        end
        S_LOAD: begin
          // Address and data settle with strobes high
          cnt_q <= 4'h0;
          if ((op_q == `FSC_OP_READ) || (op_q == `FSC_OP_POLL)) begin
            flash_addr <= addr_q;
            flash_dq_oe_n <= 15'h7FFF;
            top_data_or_low_addr_o <= addr_q[0];
            top_data_or_low_addr_oe_n <= word_q;
            // Select falls first so the read is marked by the output enable edge
            flash_ce_n <= 1'b0;
            st_q <= S_RLOW;
          end else begin
            flash_addr <= rom_addr;
            flash_dq_o <= {7'h00, rom_data};
            flash_dq_oe_n <= {7'h7F, 8'h00};
            top_data_or_low_addr_o <= 1'b0;
            top_data_or_low_addr_oe_n <= 1'b1;
            flash_ce_n <= 1'b0;
            if (word_q & (op_q == `FSC_OP_PROGRAM) & (step_q == 3'h3)) begin
              // Data cycle of a word program drives all sixteen lines
              flash_dq_o <= wdata_q[14:0];
              flash_dq_oe_n <= 15'h0000;
              top_data_or_low_addr_o <= wdata_q[15];
              top_data_or_low_addr_oe_n <= 1'b0;
            end
            st_q <= S_WLOW;
          end
        end
        S_WLOW: begin
          flash_we_n <= 1'b0;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `FSC_PHASE_CYC) begin
            // Select stays low past the write strobe edge that latches the cycle
            flash_we_n <= 1'b1;
            cnt_q <= 4'h0;
            st_q <= S_WHIGH;
          end
        end
        S_WHIGH: begin
          flash_ce_n <= 1'b1;
          flash_dq_oe_n <= 15'h7FFF;
          top_data_or_low_addr_oe_n <= 1'b1;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `FSC_PHASE_CYC) begin
            if (last_step_q) begin
              // busy follows the final strobe; poll until completion, except after a reset command
              nread_q <= 2'h0;
              if ((op_q == `FSC_OP_RESET)) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                window_q <= 1'b0;
                st_q <= S_IDLE;
              end else begin
                op_q <= `FSC_OP_POLL;
                st_q <= S_LOAD;
              end
            end else begin
              step_q <= step_q + 3'h1;
              last_step_q <= (step_q + 3'h2 == ((op_q == `FSC_OP_PROGRAM) ? 3'h4 : 3'h6));
              st_q <= S_EVAL;
            end
          end
        end
        S_EVAL: begin
          // One clock lets the table register catch up with the new step
          st_q <= S_LOAD;
        end
        S_RLOW: begin
          flash_ce_n <= 1'b0;
          flash_oe_n <= 1'b0;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `FSC_PHASE_CYC) begin
            rdata_q <= word_q ? rd_bus : {8'h00, flash_dq_i[7:0]};
            prev_q <= rdata_q;
            // strobes rise before any address change
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt_q <= 4'h0;
            st_q <= S_RHIGH;
          end
        end
        S_RHIGH: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `FSC_PHASE_CYC) begin
            window_q <= rdata_q[`FSC_BIT_EWIN];
            if (op_q == `FSC_OP_READ) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= S_IDLE;
            end else if (nread_q != 2'h2) begin
              nread_q <= nread_q + 2'h1;
              st_q <= S_RLOW;
            end else if (~toggled[`FSC_BIT_OPTOG]) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              window_q <= 1'b0;
              fail_q <= 1'b0;
              st_q <= S_IDLE;
            end else if (tlim_seen_q) begin
              // still toggling after time-limit flag: failed
              busy_q <= 1'b0;
              done_q <= 1'b1;
              fail_q <= 1'b1;
              st_q <= S_IDLE;
            end else if (polls_q == MAX_POLLS) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              fail_q <= 1'b1;
              st_q <= S_IDLE;
            end else begin
              tlim_seen_q <= rdata_q[`FSC_BIT_TLIM];
              polls_q <= polls_q + 16'h0001;
              st_q <= S_RLOW;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ### tb/fsc_flash_ctrl_monitor.sv
`timescale 1ns/1ps
module fsc_flash_ctrl_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  input wire [19:0] flash_addr,
  input wire [14:0] flash_dq_o,
  input wire [14:0] flash_dq_oe_n,
  input wire top_data_or_low_addr_oe_n,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire flash_word
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_we_phase;
    !flash_we_n [*3] ##1 flash_we_n;
  endsequence
  AST_PREADY_NEXT: assert property (s_setup |=> pready)
    else $error("pready not one cycle after setup");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response malformed");
  AST_WRITE_CYCLE: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe without select or with output enable");
  AST_WE_LEN: assert property ($fell(flash_we_n) |-> s_we_phase)
    else $error("write strobe length wrong");
  AST_DQ_HOLD: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_o) && $stable(flash_addr))
    else $error("write data moved under strobe");
  AST_READ_FLOAT: assert property (!flash_oe_n |-> &flash_dq_oe_n && flash_we_n)
    else $error("data lines driven during read");
  AST_BYTE_TRI: assert property (!flash_word |-> &flash_dq_oe_n[14:8])
    else $error("upper data lines driven in byte mode");
  AST_TOP_LINE: assert property (!flash_oe_n |-> top_data_or_low_addr_oe_n == flash_word)
    else $error("top line use wrong for width");
  AST_ADDR_QUIET: assert property (!$stable(flash_addr) |-> flash_ce_n || flash_oe_n)
    else $error("address changed during read");
endmodule
bind fsc_flash_ctrl fsc_flash_ctrl_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
  .flash_dq_oe_n(flash_dq_oe_n), .top_data_or_low_addr_oe_n(top_data_or_low_addr_oe_n),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_word(flash_word));

// ### tb/fsc_flash_model.sv
`timescale 1ns/1ps
module fsc_flash_model (
  input wire [14:0] dq_o,
  input wire top_o,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire word,
  input wire lock,
  input wire hold,
  input wire [7:0] busy_len,
  output wire [14:0] dq_m,
  output wire top_m,
  output wire rb_n
);
  logic [15:0] mem = 16'hFFFF, pdata = 16'hFFFF, st;
  logic [7:0] mem_b = 8'hFF, reads = 8'h00;
  logic [2:0] wc = 3'h0;
  logic [1:0] mode = 2'h0;
  logic arm = 1'b0, tog = 1'b0, tog2 = 1'b0, tlim = 1'b0, win = 1'b0;
  wire [7:0] cmd = dq_o[7:0];
  wire off = oe_n || ce_n;
  assign rb_n = (mode != 2'h0 || hold) ? 1'b0 : 1'bz;
  // Released lines show the inverse so a stale value never passes
  assign dq_m = off ? ~st[14:0] : st[14:0];
  assign top_m = off ? ~st[15] : st[15];
  always @(posedge we_n) if (!ce_n && oe_n) begin
    if (cmd == 8'hF0) begin
      mode <= 2'h0;
      tlim <= 1'b0;
      wc <= 3'h0;
      arm <= 1'b0;
    end else if (mode == 2'h2 && !win && cmd == 8'h30) reads <= 8'h00;
    else if (mode == 2'h0 && !hold) begin
      if (arm) begin
        mode <= 2'h1;
        pdata <= word ? {top_o, dq_o} : {8'hFF, cmd};
        arm <= 1'b0;
        wc <= 3'h0;
        reads <= 8'h00;
      end else if (wc == 3'h2 && cmd == 8'hA0) arm <= 1'b1;
      else if (wc == 3'h5 && (cmd == 8'h30 || cmd == 8'h10)) begin
        mode <= 2'h2;
        win <= 1'b0;
        wc <= 3'h0;
        reads <= 8'h00;
      // A broken sequence drops back to the first unlock cycle
      end else if (cmd == ((wc == 3'h1 || wc == 3'h4) ? 8'h55 : (wc == 3'h2) ? 8'h80 : 8'hAA)) wc <= wc + 3'h1;
      else wc <= 3'h0;
    end
  end
  always @(negedge oe_n) if (!ce_n && mode != 2'h0) begin
    reads <= reads + 8'h01;
    tog <= ~tog;
    if (mode == 2'h2) tog2 <= ~tog2;
    win <= mode == 2'h2 && reads >= 8'h01;
    if (lock && reads >= 8'h03) tlim <= 1'b1;
    if (!lock && reads >= busy_len) begin
      mode <= 2'h0;
      if (mode == 2'h2) begin
        mem <= 16'hFFFF;
        mem_b <= 8'hFF;
      end else if (word) mem <= mem & pdata;
      else mem_b <= mem_b & pdata[7:0];
    end
  end
  always_comb begin
    case (mode)
      2'h1: st = {8'h00, ~pdata[7], tog, tlim, 1'b0, 1'b0, 1'b1, 2'b00};
      2'h2: st = {8'h00, 1'b0, tog, tlim, 1'b0, win, tog2, 2'b00};
      default: st = word ? mem : {8'h00, mem_b};
    endcase
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
`include "fsc_defs.vh"
module tb;
  localparam logic [11:0] CT = `FSC_REG_CTRL;
  localparam logic [11:0] ST = `FSC_REG_STATUS;
  logic pclk = 1'b0, presetn = 1'b1, pclken = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lock = 1'b0, hold = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [7:0] busy_len = 8'h02;
  logic [15:0] mem_exp = 16'hFFFF, d;
  wire [31:0] prdata;
  wire pready, pslverr, top_o, top_oe_n, top_m, ce_n, oe_n, we_n, word;
  wire [19:0] faddr;
  wire [14:0] dq_o, dq_oe_n, dq_m;
  tri1 rb_n;
  int fails = 0, tests_run = 0, nwr = 0, wr_busy = 0;
  always #20 pclk = ~pclk;
  always @(posedge we_n) if (!ce_n) nwr++;
  always @(negedge rb_n) wr_busy = nwr;
  fsc_flash_ctrl #(.MAX_POLLS(16'h0010)) dut_u (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(faddr), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n),
    .flash_dq_i((~dq_oe_n & dq_o) | (dq_oe_n & dq_m)), .top_data_or_low_addr_o(top_o),
    .top_data_or_low_addr_oe_n(top_oe_n), .top_data_or_low_addr_i(top_oe_n ? top_m : top_o),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_word(word), .ready_busy_n(rb_n));
  fsc_flash_model mdl_u (.dq_o(dq_o), .top_o(top_o), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .word(word),
    .lock(lock), .hold(hold), .busy_len(busy_len), .dq_m(dq_m), .top_m(top_m), .rb_n(rb_n));
  task chk(input logic [31:0] v, input logic [31:0] e);
    tests_run++;
    if (v !== e) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, v, e);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop;
    end
  endtask
  // Start an operation and poll status until idle; rd ends holding the status word
  task op(input logic [2:0] code, input logic wm);
    int n;
    nwr = 0;
    wr_busy = 0;
    apb(1'b1, CT, {27'h000_0000, wm, code, 1'b1});
    n = 0;
    do begin
      apb(1'b0, ST, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      fails++;
      report_and_stop;
    end
  endtask
  task prog_read(input logic wm, input logic [19:0] a, input logic [15:0] v);
    apb(1'b1, `FSC_REG_ADDR, {12'h000, a});
    apb(1'b1, `FSC_REG_WDATA, {16'h0000, v});
    op(`FSC_OP_PROGRAM, wm);
    chk(rd[2:0], 3'b010);
    chk(wr_busy, 4);
    chk(nwr, 4);
    chk(word, wm);
    op(`FSC_OP_READ, wm);
    apb(1'b0, `FSC_REG_RDATA, 32'h0000_0000);
  endtask
  initial begin
    #4_000_000;
    fails++;
    report_and_stop;
  end
  initial begin
    presetn <= 1'b0;
    void'($urandom(32'h0000_A42E));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b0, ST, 32'h0000_0000);
    chk(rd[2:0], 3'b000);
    for (int i = 0; i < 3; i++) begin
      d = 16'($urandom);
      busy_len = (i == 0) ? 8'h02 : 8'h08;
      mem_exp = mem_exp & d;
      prog_read(1'b1, 20'($urandom), d);
      chk(rd[15:0], mem_exp);
    end
    busy_len = 8'h0C;
    op(`FSC_OP_CHIP_ERASE, 1'b1);
    chk(wr_busy, 6);
    chk(rd[2:0], 3'b010);
    op(`FSC_OP_SECTOR_ERASE, 1'b1);
    chk(wr_busy, 6);
    chk(rd[5], 1'b0);
    apb(1'b0, ST, 32'h0000_0000);
    chk(rd[5], 1'b0);
    op(`FSC_OP_ADD_SECTOR, 1'b1);
    chk(rd[3], 1'b0);
    d = 16'($urandom);
    prog_read(1'b0, {20'($urandom) & 20'hF_FFFE}, d);
    chk(rd[7:0], d[7:0]);
    hold = 1'b1;
    op(`FSC_OP_PROGRAM, 1'b1);
    chk(rd[4:3], 2'b01);
    chk(nwr, 0);
    hold = 1'b0;
    lock = 1'b1;
    op(`FSC_OP_PROGRAM, 1'b1);
    chk(rd[2], 1'b1);
    chk(rb_n, 1'b0);
    op(`FSC_OP_PROGRAM, 1'b1);
    chk(nwr, 0);
    op(`FSC_OP_RESET, 1'b1);
    chk(rd[2], 1'b0);
    chk(rb_n, 1'b1);
    lock = 1'b0;
    op(`FSC_OP_POLL, 1'b1);
    chk(rd[2:0], 3'b010);
    report_and_stop;
  end
endmodule
